// File: verilog/tpo_params.svh
// Constants of the timing pattern output block: offsets, resets, fields.
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - Four 4-bit groups update independently.
// - Fifteen usable outputs; bit 14 has no pin.
// - Each group picks one of four triggers.
// - Non-overlap mode delays rising transitions.
// - Bits 0-3 group 0, up to 12-15 group 3.
// - Direction registers are 8-bit and write-only.
// - Low port carries 7-0; high carries 15,13-8.
// - Enabled port data bits ignore software writes.
// - Trigger copies next data into port data.
// - Low next data at a5, split a7/a5.
// - High next data at a4, split a6/a4.
// - Next data cleared by reset and standby.
// - Decode only the low sixteen index bits.
// - Disabled bits are not copied, output holds.
// - Unused split nibbles ignore writes, read ones.
// - Trigger select resets to all ones.
`ifndef TPO_PARAMS_SVH
`define TPO_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define TPO_IDX_MODE       16'hffa0
`define TPO_IDX_TRIG       16'hffa1
`define TPO_IDX_EN_HIGH    16'hffa2
`define TPO_IDX_EN_LOW     16'hffa3
`define TPO_IDX_ND_HIGH    16'hffa4
`define TPO_IDX_ND_LOW     16'hffa5
`define TPO_IDX_ND_HIGH_LO 16'hffa6
`define TPO_IDX_ND_LOW_LO  16'hffa7
`define TPO_IDX_DIR_LOW    16'hffd1
`define TPO_IDX_OUT_LOW    16'hffd3
`define TPO_IDX_DIR_HIGH   16'hffd4
`define TPO_IDX_OUT_HIGH   16'hffd6

// Reset values.
`define TPO_RST_MODE       8'hf0
`define TPO_RST_TRIG       8'hff
`define TPO_RST_ZERO       8'h00

// Field layout.
`define TPO_NIBBLE_ONES    4'hf
`define TPO_NO_PIN_BIT     6
`define TPO_IDX_LSB        2
`define TPO_IDX_MSB        17

`endif

// File: verilog/tpo_pkg.sv
// Types shared by the timing pattern output block.
package tpo_pkg;

	// A pair of 8-bit registers covering the 16 pattern bits.
	typedef struct packed {
		logic [7:0] high; // Bits 15 to 8, groups 3 and 2.
		logic [7:0] low;  // Bits 7 to 0, groups 1 and 0.
	} tpo_pair_t;

	// Register selected by the current bus address.
	typedef enum logic [3:0] {
		TPO_R_NONE, TPO_R_MODE, TPO_R_TRIG, TPO_R_EN_HIGH, TPO_R_EN_LOW,
		TPO_R_ND_HIGH, TPO_R_ND_LOW, TPO_R_ND_HIGH_LO, TPO_R_ND_LOW_LO,
		TPO_R_DIR_LOW, TPO_R_OUT_LOW, TPO_R_DIR_HIGH, TPO_R_OUT_HIGH
	} tpo_reg_t;

endpackage : tpo_pkg

// File: verilog/tpo_top.sv
// Timing pattern output block with an APB register slave.
`timescale 1ns/1ps
`include "tpo_params.svh"

module tpo_top
	import tpo_pkg::*;
(
	input  wire logic        pclk,          // System clock.
	input  wire logic        presetn,       // Asynchronous reset, low.
	input  wire logic        psel,          // APB select.
	input  wire logic        penable,       // APB access phase.
	input  wire logic        pwrite,        // APB direction.
	input  wire logic [31:0] paddr,         // APB byte address.
	input  wire logic [31:0] pwdata,        // APB write data.
	input  wire logic [3:0]  pstrb,         // APB byte strobes.
	output logic      [31:0] prdata,        // APB read data.
	output logic             pready,        // APB ready.
	output logic             pslverr,       // APB error.
	input  wire logic        hw_standby,    // Hardware standby, high.
	input  wire logic [3:0]  compare_match, // Timer channel events.
	output logic      [7:0]  low_pin_out,   // Low port pin levels.
	output logic      [7:0]  low_pin_oe,    // Low port drive enables.
	output logic      [7:0]  high_pin_out,  // High port pin levels.
	output logic      [7:0]  high_pin_oe    // High port drive enables.
);

	//------------------------------------------------------------------
	// Storage
	//------------------------------------------------------------------
	logic [7:0]  output_mode;    // Low nibble: non-overlap per group.
	logic [7:0]  trigger_select; // Two select bits per group.
	tpo_pair_t   next_enable;    // Per-bit pattern enables.
	tpo_pair_t   next_data;      // Staged pattern data.
	tpo_pair_t   port_data;      // Port output data registers.
	logic [15:0] rise_pend;      // Rising bits held back one cycle.

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------

	// Returns the event chosen for a group by its two select bits.
	function automatic logic group_event(input logic [7:0] sel,
		input logic [3:0] cm, input int g);
		logic [1:0] s;
		s = sel[2*g +: 2];
		return cm[s];
	endfunction : group_event

	// Tells whether two groups share their trigger selection.
	function automatic logic same_trig(input logic [7:0] sel,
		input int g);
		return sel[2*g +: 2] == sel[2*g+2 +: 2];
	endfunction : same_trig

	//------------------------------------------------------------------
	// Trigger selection
	//------------------------------------------------------------------
	logic [3:0]  grp_fire; // One bit per group, high on its event.
	logic [15:0] bit_fire; // Group events spread to the 16 bits.
	logic [15:0] bit_novl; // Non-overlap setting spread to bits.

	// Each group takes its own event, one group per nibble.
	always_comb
	begin
		for (int g = 0; g < 4; g++)
		begin
			grp_fire[g] = group_event(trigger_select, compare_match,
				g);
			bit_fire[4*g +: 4] = {4{grp_fire[g]}};
			bit_novl[4*g +: 4] = {4{output_mode[g]}};
		end
	end

	//------------------------------------------------------------------
	// Address decode
	//------------------------------------------------------------------
	logic [15:0] reg_index; // Register index from the bus address.
	tpo_reg_t    reg_sel;   // Decoded register.
	logic        acc_done;  // Access completes at this edge.
	logic        wr_en;     // Completed write.
	logic        wr_byte;   // Low byte lane written.
	logic [7:0]  wbyte;     // Low byte of the write data.

	// Only the low sixteen index bits take part in decode.
	assign reg_index = paddr[`TPO_IDX_MSB:`TPO_IDX_LSB];
	assign acc_done  = psel && penable && pready;
	assign wr_en     = acc_done && pwrite;
	assign wr_byte   = wr_en && pstrb[0];
	assign wbyte     = pwdata[7:0];

	// Maps the index onto one register or none.
	always_comb
	begin
		unique case (reg_index)
			`TPO_IDX_MODE:       reg_sel = TPO_R_MODE;
			`TPO_IDX_TRIG:       reg_sel = TPO_R_TRIG;
			`TPO_IDX_EN_HIGH:    reg_sel = TPO_R_EN_HIGH;
			`TPO_IDX_EN_LOW:     reg_sel = TPO_R_EN_LOW;
			`TPO_IDX_ND_HIGH:    reg_sel = TPO_R_ND_HIGH;
			`TPO_IDX_ND_LOW:     reg_sel = TPO_R_ND_LOW;
			`TPO_IDX_ND_HIGH_LO: reg_sel = TPO_R_ND_HIGH_LO;
			`TPO_IDX_ND_LOW_LO:  reg_sel = TPO_R_ND_LOW_LO;
			`TPO_IDX_DIR_LOW:    reg_sel = TPO_R_DIR_LOW;
			`TPO_IDX_OUT_LOW:    reg_sel = TPO_R_OUT_LOW;
			`TPO_IDX_DIR_HIGH:   reg_sel = TPO_R_DIR_HIGH;
			`TPO_IDX_OUT_HIGH:   reg_sel = TPO_R_OUT_HIGH;
			default:             reg_sel = TPO_R_NONE;
		endcase
	end

	//------------------------------------------------------------------
	// Bus answer
	//------------------------------------------------------------------
	logic [7:0] next_rd; // Read value of the addressed register.

	// Builds read data; split next-data nibbles show ones elsewhere.
	always_comb
	begin
		next_rd = 8'h00;
		unique case (reg_sel)
			TPO_R_MODE:    next_rd = output_mode;
			TPO_R_TRIG:    next_rd = trigger_select;
			TPO_R_EN_HIGH: next_rd = next_enable.high;
			TPO_R_EN_LOW:  next_rd = next_enable.low;
			TPO_R_OUT_LOW: next_rd = port_data.low;
			TPO_R_OUT_HIGH: next_rd = port_data.high;
			TPO_R_ND_HIGH: next_rd = same_trig(trigger_select, 2) ?
				next_data.high :
				{next_data.high[7:4], `TPO_NIBBLE_ONES};
			TPO_R_ND_LOW:  next_rd = same_trig(trigger_select, 0) ?
				next_data.low :
				{next_data.low[7:4], `TPO_NIBBLE_ONES};
			TPO_R_ND_HIGH_LO: next_rd = same_trig(trigger_select, 2) ?
				8'hff : {`TPO_NIBBLE_ONES, next_data.high[3:0]};
			TPO_R_ND_LOW_LO: next_rd = same_trig(trigger_select, 0) ?
				8'hff : {`TPO_NIBBLE_ONES, next_data.low[3:0]};
			// Direction registers cannot be read back.
			TPO_R_DIR_LOW, TPO_R_DIR_HIGH: next_rd = 8'h00;
			TPO_R_NONE:    next_rd = 8'h00;
		endcase
	end

	// One wait state, then a registered answer with data and error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			prdata  <= {24'h00_0000, next_rd};
			pslverr <= psel && penable && !pready && reg_sel == TPO_R_NONE;
		end
	end

	//------------------------------------------------------------------
	// Control registers
	//------------------------------------------------------------------

	// Mode, trigger select and enables; standby clears like reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			output_mode    <= `TPO_RST_MODE;
			trigger_select <= `TPO_RST_TRIG;
			next_enable    <= '0;
		end
		else if (hw_standby)
		begin
			output_mode    <= `TPO_RST_MODE;
			trigger_select <= `TPO_RST_TRIG;
			next_enable    <= '0;
		end
		else if (wr_byte)
		begin
			// Upper mode bits are reserved and stay at one.
			if (reg_sel == TPO_R_MODE)
				output_mode <= {`TPO_NIBBLE_ONES, wbyte[3:0]};
			if (reg_sel == TPO_R_TRIG)
				trigger_select <= wbyte;
			if (reg_sel == TPO_R_EN_HIGH)
				next_enable.high <= wbyte;
			if (reg_sel == TPO_R_EN_LOW)
				next_enable.low <= wbyte;
		end
	end

	// Next data; the nibble written depends on trigger sharing.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			next_data <= '0;
		else if (hw_standby)
			next_data <= '0;
		else if (wr_byte)
		begin
			if (reg_sel == TPO_R_ND_LOW)
			begin
				next_data.low[7:4] <= wbyte[7:4];
				if (same_trig(trigger_select, 0))
					next_data.low[3:0] <= wbyte[3:0];
			end
			if (reg_sel == TPO_R_ND_LOW_LO && !same_trig(trigger_select, 0))
				next_data.low[3:0] <= wbyte[3:0];
			if (reg_sel == TPO_R_ND_HIGH)
			begin
				next_data.high[7:4] <= wbyte[7:4];
				if (same_trig(trigger_select, 2))
					next_data.high[3:0] <= wbyte[3:0];
			end
			if (reg_sel == TPO_R_ND_HIGH_LO &&
				!same_trig(trigger_select, 2))
				next_data.high[3:0] <= wbyte[3:0];
		end
	end

	// Direction registers drive the pin enables directly.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_pin_oe  <= `TPO_RST_ZERO;
			high_pin_oe <= `TPO_RST_ZERO;
		end
		else if (hw_standby)
		begin
			low_pin_oe  <= `TPO_RST_ZERO;
			high_pin_oe <= `TPO_RST_ZERO;
		end
		else if (wr_byte)
		begin
			if (reg_sel == TPO_R_DIR_LOW)
				low_pin_oe <= wbyte;
			if (reg_sel == TPO_R_DIR_HIGH)
			begin
				high_pin_oe <= wbyte;
				// Pattern bit 14 has no pin and is never driven.
				high_pin_oe[`TPO_NO_PIN_BIT] <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------------
	// Pattern transfer
	//------------------------------------------------------------------
	logic [15:0] en16;   // Enables as one vector.
	logic [15:0] nd16;   // Next data as one vector.
	logic [15:0] pd16;   // Port data as one vector.
	logic [15:0] sw_wr;  // Software write strobe per bit.
	logic [15:0] sw_val; // Software write value per bit.

	assign en16   = next_enable;
	assign nd16   = next_data;
	assign pd16   = port_data;
	assign sw_wr  = {{8{wr_byte && reg_sel == TPO_R_OUT_HIGH}},
		{8{wr_byte && reg_sel == TPO_R_OUT_LOW}}};
	assign sw_val = {wbyte, wbyte};

	// Per bit: trigger copy, delayed rise, or a software write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_data <= '0;
			rise_pend <= 16'h0000;
		end
		else if (hw_standby)
		begin
			port_data <= '0;
			rise_pend <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < 16; i++)
			begin
				if (en16[i] && bit_fire[i])
				begin
					// Copy at this very edge; rises wait in non-overlap.
					if (bit_novl[i] && nd16[i] && !pd16[i])
						rise_pend[i] <= 1'b1;
					else
					begin
						port_data[i] <= nd16[i];
						rise_pend[i] <= 1'b0;
					end
				end
				else if (rise_pend[i])
				begin
					// Margin elapsed: the held rise now takes effect.
					port_data[i] <= 1'b1;
					rise_pend[i] <= 1'b0;
				end
				else if (sw_wr[i] && !en16[i])
					// Bits used for pattern output are read-only.
					port_data[i] <= sw_val[i];
			end
		end
	end

	// Pins follow the port data registers, bit 14 included; its drive enable stays low.
	assign low_pin_out  = port_data.low;
	assign high_pin_out = port_data.high;

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A completed write of a port bit in pattern use.
	sequence s_locked_write(int i);
		sw_wr[i] && en16[i] && !bit_fire[i] && !rise_pend[i];
	endsequence

	a_copy_on_fire: assert property (
		(!hw_standby && en16[0] && bit_fire[0] && !bit_novl[0])
		|=> low_pin_out[0] == $past(nd16[0]))
		else $error("enabled bit 0 missed its trigger copy");

	a_group_indep: assert property (
		(!hw_standby && !grp_fire[1] && !rise_pend[4] && !sw_wr[4])
		|=> low_pin_out[4] == $past(low_pin_out[4]))
		else $error("group 1 moved without its own event");

	a_disabled_hold: assert property (
		(!hw_standby && !en16[9] && !rise_pend[9] && !sw_wr[9])
		|=> $stable(high_pin_out[1]))
		else $error("disabled bit 9 changed");

	a_locked_bit: assert property (
		(!hw_standby and s_locked_write(2)) |=> $stable(low_pin_out[2]))
		else $error("software changed a pattern bit");

	a_no_pin14: assert property (
		high_pin_oe[`TPO_NO_PIN_BIT] == 1'b0)
		else $error("bit 14 pin is being driven");

	a_trig_sel: assert property (
		grp_fire[3] == compare_match[trigger_select[7:6]])
		else $error("group 3 used the wrong event");

	// An enabled rise of bit 0 that non-overlap mode must hold back.
	sequence s_held_rise;
		!hw_standby && en16[0] && bit_fire[0] && bit_novl[0] &&
		nd16[0] && !low_pin_out[0];
	endsequence

	// The held rise lands one cycle late unless standby or a new copy
	// comes in between.
	a_novl_rise: assert property (
		s_held_rise |=> !low_pin_out[0] ##1
		(low_pin_out[0] || $past(hw_standby) || $past(bit_fire[0])))
		else $error("non-overlap rise not delayed one cycle");

	a_split_read: assert property (
		(psel && penable && !pready && !pwrite &&
		reg_sel == TPO_R_ND_LOW_LO && !same_trig(trigger_select, 0))
		|=> prdata[7:4] == `TPO_NIBBLE_ONES)
		else $error("reserved nibble read as zero");

	a_apb_ready: assert property (
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("ready not a single cycle after one wait");

	a_standby_clr: assert property (
		hw_standby |=> next_data == '0 &&
		trigger_select == `TPO_RST_TRIG)
		else $error("standby did not clear registers");

endmodule : tpo_top

// File: verification/tpo_timer_model.sv
// Timer unit stand-in that raises compare-match events on request.
`timescale 1ns/1ps

module tpo_timer_model
	import tpo_pkg::*;
(
	input  wire logic       pclk,          // System clock.
	input  wire logic       presetn,       // Asynchronous reset, low.
	input  wire logic [3:0] fire_req,      // One-cycle request per channel.
	output logic      [3:0] compare_match  // Events of channels 0 to 3.
);
	// Each request becomes a one-cycle event pulse on its own channel.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			compare_match <= 4'h0;
		else
			compare_match <= fire_req;
	end
endmodule : tpo_timer_model

// File: verification/timing_pattern_output_bench.sv
// Self-checking bench of the timing pattern output block.
`timescale 1ns/1ps
`include "tpo_params.svh"

module timing_pattern_output_bench
	import tpo_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, hw_standby;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0]  pstrb, compare_match, fire_req;
	logic        pready, pslverr;
	logic [7:0]  low_pin_out, low_pin_oe, high_pin_out, high_pin_oe;
	int          n_fail, comparisons;

	tpo_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_standby(hw_standby),
		.compare_match(compare_match), .low_pin_out(low_pin_out),
		.low_pin_oe(low_pin_oe), .high_pin_out(high_pin_out),
		.high_pin_oe(high_pin_oe));

	tpo_timer_model timer (.pclk(pclk), .presetn(presetn),
		.fire_req(fire_req), .compare_match(compare_match));

	// The 4 ns clock.
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// Compares one byte and reports a difference at once.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL %0t %s seen %h expected %h", $time, what, seen,
				exp);
		end
	endtask : chk

	// One APB transfer; the upper address bits are junk on purpose.
	task automatic apb(input logic w, input logic [15:0] idx,
		input logic [7:0] wd, output logic [7:0] rd, output logic err);
		int n;
		n = 0;
		// Setup starts just after a rising edge, whatever came before.
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h1555, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// Ready is sampled at rising edges; data is taken at that edge.
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			chk(8'h00, 8'h01, "no ready");
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Register write.
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [7:0] rd;
		logic       err;
		apb(1'b1, idx, d, rd, err);
	endtask : wr

	// Register read compared with an expected byte, without error.
	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
		logic [7:0] rd;
		logic       err;
		apb(1'b0, idx, 8'h00, rd, err);
		chk(rd, exp, "register read");
		chk({7'h0, err}, 8'h00, "read error flag");
	endtask : rd_chk

	// Fires one timer channel and returns in the cycle after the copy.
	task automatic pulse(input int ch);
		@(posedge pclk);
		fire_req <= 4'h1 << ch;
		@(posedge pclk);
		fire_req <= 4'h0;
		@(posedge pclk);
		@(negedge pclk);
	endtask : pulse

	//----------------------------------------------------------------
	// Scenarios
	//----------------------------------------------------------------
	// Reset values and an unmapped access.
	task automatic t_reset;
		logic [7:0] rd;
		logic       err;
		rd_chk(`TPO_IDX_MODE, `TPO_RST_MODE);
		rd_chk(`TPO_IDX_TRIG, `TPO_RST_TRIG);
		rd_chk(`TPO_IDX_EN_LOW, 8'h00);
		rd_chk(`TPO_IDX_EN_HIGH, 8'h00);
		rd_chk(`TPO_IDX_ND_LOW, 8'h00);
		rd_chk(`TPO_IDX_ND_HIGH, 8'h00);
		rd_chk(`TPO_IDX_OUT_HIGH, 8'h00);
		apb(1'b0, 16'h1234, 8'h00, rd, err);
		chk({7'h0, err}, 8'h01, "unmapped error");
	endtask : t_reset

	// Direction registers drive the pin enables; bit 14 has no pin.
	task automatic t_dir;
		wr(`TPO_IDX_DIR_LOW, 8'hff);
		wr(`TPO_IDX_DIR_HIGH, 8'hff);
		chk(low_pin_oe, 8'hff, "low enables");
		chk(high_pin_oe, 8'hbf, "high enables");
		rd_chk(`TPO_IDX_DIR_LOW, 8'h00);
	endtask : t_dir

	// Shared trigger: copy of enabled bits only, locked port bits.
	task automatic t_copy;
		wr(`TPO_IDX_TRIG, 8'h00);
		wr(`TPO_IDX_EN_LOW, 8'h0f);
		wr(`TPO_IDX_ND_LOW, 8'ha5);
		pulse(0);
		chk(low_pin_out, 8'h05, "copy on event");
		wr(`TPO_IDX_OUT_LOW, 8'hff);
		rd_chk(`TPO_IDX_OUT_LOW, 8'hf5);
		pulse(1);
		chk(low_pin_out, 8'hf5, "other channel");
		rd_chk(`TPO_IDX_ND_LOW_LO, 8'hff);
		wr(`TPO_IDX_ND_LOW_LO, 8'h00);
		rd_chk(`TPO_IDX_ND_LOW, 8'ha5);
	endtask : t_copy

	// Separate triggers for every group and split next data places.
	task automatic t_split;
		wr(`TPO_IDX_TRIG, 8'he4);
		wr(`TPO_IDX_EN_LOW, 8'hff);
		wr(`TPO_IDX_EN_HIGH, 8'hff);
		wr(`TPO_IDX_ND_LOW, 8'h9c);
		wr(`TPO_IDX_ND_LOW_LO, 8'h3e);
		wr(`TPO_IDX_ND_HIGH, 8'h7b);
		wr(`TPO_IDX_ND_HIGH_LO, 8'h62);
		rd_chk(`TPO_IDX_ND_LOW, 8'h9f);
		rd_chk(`TPO_IDX_ND_LOW_LO, 8'hfe);
		rd_chk(`TPO_IDX_ND_HIGH, 8'h7f);
		rd_chk(`TPO_IDX_ND_HIGH_LO, 8'hf2);
		pulse(1);
		chk(low_pin_out, 8'h95, "group 1 alone");
		pulse(0);
		chk(low_pin_out, 8'h9e, "group 0 alone");
		pulse(3);
		chk(high_pin_out, 8'h70, "group 3 alone");
		pulse(2);
		chk(high_pin_out, 8'h72, "group 2 alone");
	endtask : t_split

	// Non-overlap: falling bits at once, the rising bit a cycle later.
	task automatic t_nonoverlap;
		wr(`TPO_IDX_MODE, 8'h01);
		rd_chk(`TPO_IDX_MODE, 8'hf1);
		wr(`TPO_IDX_ND_LOW_LO, 8'h01);
		pulse(0);
		chk(low_pin_out, 8'h90, "falling first");
		@(negedge pclk);
		chk(low_pin_out, 8'h91, "rising later");
	endtask : t_nonoverlap

	// Hardware standby clears like reset.
	task automatic t_standby;
		@(posedge pclk);
		hw_standby <= 1'b1;
		@(posedge pclk);
		hw_standby <= 1'b0;
		@(posedge pclk);
		chk(low_pin_out, 8'h00, "pins cleared");
		chk(low_pin_oe, 8'h00, "enables cleared");
		rd_chk(`TPO_IDX_ND_LOW, 8'h00);
		rd_chk(`TPO_IDX_TRIG, `TPO_RST_TRIG);
	endtask : t_standby

	// Main sequence: reset for 16 cycles, then every scenario.
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'h1;
		hw_standby = 1'b0;
		fire_req = 4'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_dir;
		t_copy;
		t_split;
		t_nonoverlap;
		t_standby;
		wrap_up;
	end

	// Watchdog far beyond the few hundred cycles the tests need.
	initial
	begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		wrap_up;
	end
endmodule : timing_pattern_output_bench
